/* File: logic/lcsfd_pkg.sv */
// Constants and types shared by the link channel status, data port and input DMA logic
package lcsfd_pkg;

	// ****************************************
	// Register offsets
	// ****************************************
	localparam int         ADDR_W      = 8;
	localparam logic [7:0] OFF_STATUS  = 8'h14;
	localparam logic [7:0] OFF_DATA    = 8'h18;
	localparam logic [7:0] OFF_DMA_PTR = 8'h1c;

	// ****************************************
	// Status word layout
	// ****************************************
	localparam int B_TX_EMPTY = 0, B_TX_AE = 1, B_TX_FULL = 2, B_TX_VALID = 3;
	localparam int B_RX_EMPTY = 4, B_RX_AF = 5, B_RX_FULL = 6, B_RX_VALID = 7;
	localparam int B_PARITY = 8, B_DISC = 9, B_ESC = 10, B_CREDIT = 11;
	localparam int B_OVFL = 12, B_RX_ERR = 13, B_PKT = 14, B_TICK = 15;
	localparam int B_WR_DONE = 16, B_RD_DONE = 17, B_WR_ERR = 18, B_RD_ERR = 19;
	localparam int B_LINK_RUN = 20, B_PURGE = 21, B_PLEN_VALID = 22, B_INT_ACT = 23;
	localparam int B_TC_LO = 24, B_TX_AE_LAT = 30, B_RX_AF_LAT = 31;
	localparam logic [31:0] STAT_W1C_MASK = 32'hc02fff00;
	localparam logic [31:0] STAT_RESET    = 32'h0000_0000;

	// ****************************************
	// Sizes and descriptor fields
	// ****************************************
	localparam int CNT_W      = 11;
	localparam int PF_DEPTH   = 4;
	localparam int TC_W       = 6;
	localparam int LEN_BITS   = 22;
	localparam int WORD_SHIFT = 2;
	localparam int SEG_W      = LEN_BITS - WORD_SHIFT;
	localparam int DIR_BIT    = 1;
	localparam int EOC_BIT    = 0;

	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_PERIOD_NS = 4;
	localparam int DISC_TIME_NS  = 850;
	localparam int DISC_CYCLES   = (DISC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PURGE_TIME_NS = 30000;
	localparam int PURGE_CYCLES  = PURGE_TIME_NS / CLK_PERIOD_NS;
	localparam int PURGE_W       = 13;

	typedef enum logic [2:0] {
		DMA_IDLE = 3'h0,
		DMA_ADDR = 3'h1,
		DMA_LEN  = 3'h2,
		DMA_NEXT = 3'h3,
		DMA_XFER = 3'h4
	} lcsfd_dma_state_t;

endpackage

/* File: logic/lcsfd_dma_if.sv */
// Command and status path between the channel logic and the input DMA chain engine
`timescale 1ns/10ps
`default_nettype none
interface lcsfd_dma_if;
	logic        start;
	logic        abort;
	logic [31:0] ptr;
	logic        done;
	logic        err;
	logic        busy;
	modport ctl (output start, abort, ptr, input done, err, busy);
	modport eng (input start, abort, ptr, output done, err, busy);
endinterface
`default_nettype wire

/* File: logic/lcsfd_timecode.sv */
// Time-code store and tick validation
`timescale 1ns/10ps
`default_nettype none
module lcsfd_timecode
	import lcsfd_pkg::*;
(
	// Clock and reset
	input  wire logic            core_clk,
	input  wire logic            reset,
	// Received code
	input  wire logic            tc_strobe,
	input  wire logic [TC_W-1:0] tc_code,
	// Result
	output logic      [TC_W-1:0] tc_value,
	output logic                 tc_tick
);
	logic [TC_W-1:0] next_code;
	assign next_code = tc_value + 6'h01;

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			tc_value <= 6'h00;
			tc_tick  <= 1'b0;
		end else begin
			tc_tick <= tc_strobe && (tc_code == next_code);
			if (tc_strobe && tc_code != tc_value) begin
				tc_value <= tc_code;
			end
		end
	end

	AST_TC_TICK: assert property (@(posedge core_clk) disable iff (reset)
		tc_strobe && tc_code != next_code |=> !tc_tick)
		else $error("tick raised for a non-consecutive time code");
endmodule // lcsfd_timecode
`default_nettype wire

/* File: logic/lcsfd_dma_chain.sv */
// Scatter-gather descriptor chain walker for the input DMA
`timescale 1ns/10ps
`default_nettype none
module lcsfd_dma_chain
	import lcsfd_pkg::*;
(
	// Clock and reset
	input  wire logic             core_clk,
	input  wire logic             reset,
	// Command path
	lcsfd_dma_if.eng              dma,
	// Descriptor reads
	output logic                  mem_rd_req,
	output logic      [31:0]      mem_rd_addr,
	input  wire logic             mem_rd_ack,
	input  wire logic [31:0]      mem_rd_data,
	input  wire logic             mem_abort,
	// Segment hand-off to the data mover
	output logic                  seg_start,
	output logic      [31:0]      seg_addr,
	output logic      [SEG_W-1:0] seg_words,
	input  wire logic             seg_done
);
	lcsfd_dma_state_t state;
	logic [31:0]      next_ptr;

	assign mem_rd_req = state == DMA_ADDR || state == DMA_LEN || state == DMA_NEXT;
	assign dma.busy   = state != DMA_IDLE;

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			state       <= DMA_IDLE;
			mem_rd_addr <= 32'h0000_0000;
			next_ptr    <= 32'h0000_0000;
			seg_addr    <= 32'h0000_0000;
			seg_words   <= 20'h00000;
			seg_start   <= 1'b0;
			dma.done    <= 1'b0;
			dma.err     <= 1'b0;
		end else begin
			seg_start <= 1'b0;
			dma.done  <= 1'b0;
			dma.err   <= 1'b0;
			if (dma.abort) begin
				state <= DMA_IDLE;
			end else if (dma.start) begin
				mem_rd_addr <= dma.ptr;
				dma.err     <= dma.ptr[DIR_BIT];
				state       <= dma.ptr[DIR_BIT] ? DMA_IDLE : DMA_ADDR;
			end else if (mem_abort && state != DMA_IDLE) begin
				dma.err <= 1'b1;
				state   <= DMA_IDLE;
			end else begin
				unique case (state)
					DMA_IDLE: begin
					end
					DMA_ADDR, DMA_LEN, DMA_NEXT: if (mem_rd_ack) begin
						mem_rd_addr <= mem_rd_addr + 32'h4;
						if (state == DMA_ADDR) begin
							seg_addr <= mem_rd_data;
							state    <= DMA_LEN;
						end else if (state == DMA_LEN) begin
							seg_words <= mem_rd_data[LEN_BITS-1:WORD_SHIFT];
							state     <= DMA_NEXT;
						end else if (mem_rd_data[DIR_BIT]) begin
							dma.err <= 1'b1;
							state   <= DMA_IDLE;
						end else begin
							next_ptr  <= mem_rd_data;
							seg_start <= seg_words != 20'h00000;
							state     <= DMA_XFER;
						end
					end
					DMA_XFER: if (seg_done || seg_words == 20'h00000) begin
						mem_rd_addr <= {next_ptr[31:2], 2'b00};
						dma.done    <= next_ptr[EOC_BIT];
						state       <= next_ptr[EOC_BIT] ? DMA_IDLE : DMA_ADDR;
					end
				endcase
			end
		end
	end

	sequence s_start_ok;
		dma.start && !dma.abort && !dma.ptr[DIR_BIT];
	endsequence
	sequence s_three_fetches;
		state == DMA_ADDR ##[1:64] state == DMA_LEN ##[1:64] state == DMA_NEXT;
	endsequence

	AST_DMA_FETCH: assert property (@(posedge core_clk) disable iff (reset)
		s_start_ok |=> state == DMA_ADDR && mem_rd_addr == $past(dma.ptr))
		else $error("descriptor fetch did not begin at the written pointer");
	AST_DMA_ORDER: assert property (@(posedge core_clk) disable iff (reset)
		state == DMA_XFER && $past(state) != DMA_XFER |-> $past(state) == DMA_NEXT)
		else $error("segment started before all three descriptor words");
	AST_DMA_ABORT: assert property (@(posedge core_clk) disable iff (reset)
		dma.abort |=> state == DMA_IDLE && !dma.done)
		else $error("zero pointer write did not abort the chain");
endmodule // lcsfd_dma_chain
`default_nettype wire

/* File: logic/lcsfd_top.sv */
// Channel status word, data port with prefetch latches and input DMA pointer port
`timescale 1ns/10ps
`default_nettype none

module lcsfd_top
	import lcsfd_pkg::*;
#(
	parameter int PURGE_CYC = PURGE_CYCLES
) (
	// Clock and reset
	input  wire logic              core_clk,
	input  wire logic              reset,
	// Host register port
	input  wire logic              host_wr,
	input  wire logic              host_rd,
	input  wire logic [ADDR_W-1:0] host_addr,
	input  wire logic [31:0]       host_wdata,
	output logic      [31:0]       host_rdata,
	output logic                   host_irq,
	// Channel control bits
	input  wire logic              tx_enable,
	input  wire logic              bypass_enable,
	input  wire logic              link_enable,
	input  wire logic              master_int_en,
	input  wire logic              tx_ae_int_en,
	input  wire logic              rx_af_int_en,
	input  wire logic              rx_err_int_en,
	input  wire logic              pkt_int_en,
	input  wire logic              tick_int_en,
	input  wire logic              force_int,
	input  wire logic              wr_dma_int_en,
	input  wire logic              rd_dma_int_en,
	input  wire logic [CNT_W-1:0]  tx_low_threshold,
	input  wire logic [CNT_W-1:0]  rx_high_threshold,
	// Transmit FIFO
	input  wire logic [CNT_W-1:0]  tx_fifo_count,
	input  wire logic              tx_fifo_full,
	output logic                   tx_fifo_push,
	output logic      [31:0]       tx_fifo_wdata,
	output logic                   tx_fifo_pop,
	input  wire logic [31:0]       tx_fifo_rdata,
	output logic      [31:0]       tx_word,
	output logic                   tx_word_valid,
	input  wire logic              tx_word_take,
	// Receive FIFO
	input  wire logic [CNT_W-1:0]  rx_fifo_count,
	input  wire logic              rx_fifo_full,
	output logic                   rx_fifo_pop,
	input  wire logic [31:0]       rx_fifo_rdata,
	output logic      [31:0]       rx_dma_word,
	output logic                   rx_dma_valid,
	input  wire logic              rx_dma_take,
	// Receive events
	input  wire logic              rx_fifo_wr_try,
	input  wire logic              rx_plen_wr_try,
	input  wire logic              rx_plen_full,
	input  wire logic              rx_plen_avail,
	input  wire logic              parity_err,
	input  wire logic              escape_err,
	input  wire logic              credit_err,
	input  wire logic              pkt_received,
	input  wire logic              tc_strobe,
	input  wire logic [TC_W-1:0]   tc_code,
	// Link pins and state
	input  wire logic              lnk_data_in,
	input  wire logic              lnk_strobe_in,
	input  wire logic              link_run,
	input  wire logic              tx_link_err,
	input  wire logic              tx_pkt_pending,
	output logic                   tx_purge_active,
	// Descriptor reads and segments
	output logic                   mem_rd_req,
	output logic      [31:0]       mem_rd_addr,
	input  wire logic              mem_rd_ack,
	input  wire logic [31:0]       mem_rd_data,
	input  wire logic              mem_abort,
	output logic                   seg_start,
	output logic      [31:0]       seg_addr,
	output logic      [SEG_W-1:0]  seg_words,
	input  wire logic              seg_done,
	// Output DMA results
	input  wire logic              rd_dma_done,
	input  wire logic              rd_dma_err
);
	localparam logic [7:0]         DISC_LIMIT = 8'(DISC_CYCLES);
	localparam logic [PURGE_W-1:0] PURGE_LIM  = PURGE_W'(PURGE_CYC);

	// ****************************************
	// Address decode
	// ****************************************
	logic stat_wr;
	logic data_wr;
	logic data_rd;
	logic ptr_wr;
	assign stat_wr = host_wr && host_addr == OFF_STATUS;
	assign data_wr = host_wr && host_addr == OFF_DATA;
	assign data_rd = host_rd && host_addr == OFF_DATA;
	assign ptr_wr  = host_wr && host_addr == OFF_DMA_PTR;

	// ****************************************
	// Transmit path
	// ****************************************
	logic tx_pop_pend;
	assign tx_fifo_pop = (tx_enable || bypass_enable) && !tx_word_valid && !tx_pop_pend
		&& tx_fifo_count != 11'h000;

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			tx_fifo_push  <= 1'b0;
			tx_fifo_wdata <= 32'h0000_0000;
		end else begin
			tx_fifo_push  <= data_wr;
			tx_fifo_wdata <= host_wdata;
		end
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			tx_pop_pend   <= 1'b0;
			tx_word_valid <= 1'b0;
			tx_word       <= 32'h0000_0000;
		end else begin
			tx_pop_pend <= tx_fifo_pop;
			if (tx_pop_pend) begin
				tx_word       <= tx_fifo_rdata;
				tx_word_valid <= 1'b1;
			end else if (tx_word_take) begin
				tx_word_valid <= 1'b0;
			end
		end
	end

	// ****************************************
	// Receive prefetch latches
	// ****************************************
	logic [31:0] pf_data [PF_DEPTH];
	logic [2:0]  pf_count;
	logic        rx_pop_pend;
	logic        pf_take;
	logic [2:0]  pf_wr_idx;

	assign rx_dma_word  = pf_data[0];
	assign rx_dma_valid = pf_count != 3'h0 && !data_rd;
	assign pf_take      = pf_count != 3'h0 && (data_rd || rx_dma_take);
	assign pf_wr_idx    = pf_count - {2'b00, pf_take};
	assign rx_fifo_pop  = !rx_pop_pend && rx_fifo_count != 11'h000
		&& pf_count < 3'(PF_DEPTH);

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			pf_count    <= 3'h0;
			rx_pop_pend <= 1'b0;
		end else begin
			rx_pop_pend <= rx_fifo_pop;
			pf_count    <= pf_count + {2'b00, rx_pop_pend} - {2'b00, pf_take};
		end
	end

	always_ff @(posedge core_clk) begin
		for (int i = 0; i < PF_DEPTH; i++) begin
			if (rx_pop_pend && 3'(i) == pf_wr_idx) begin
				pf_data[i] <= rx_fifo_rdata;
			end else if (pf_take && i < PF_DEPTH - 1) begin
				pf_data[i] <= pf_data[i+1];
			end
		end
	end

	// ****************************************
	// Disconnect detection
	// ****************************************
	logic [2:0] data_sync;
	logic [2:0] strb_sync;
	logic [7:0] idle_cnt;
	logic       line_edge;
	logic       disc_hit;

	assign line_edge = (data_sync[1] ^ data_sync[2]) || (strb_sync[1] ^ strb_sync[2]);
	assign disc_hit  = link_enable && !line_edge && idle_cnt == DISC_LIMIT - 8'h01;

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			data_sync <= 3'h0;
			strb_sync <= 3'h0;
			idle_cnt  <= 8'h00;
		end else begin
			data_sync <= {data_sync[1:0], lnk_data_in};
			strb_sync <= {strb_sync[1:0], lnk_strobe_in};
			if (!link_enable || line_edge) begin
				idle_cnt <= 8'h00;
			end else if (idle_cnt != DISC_LIMIT) begin
				idle_cnt <= idle_cnt + 8'h01;
			end
		end
	end

	// ****************************************
	// Transmit purge timer
	// ****************************************
	logic [PURGE_W-1:0] purge_cnt;
	logic               purge_fail;
	assign purge_fail = tx_purge_active && purge_cnt == PURGE_LIM - 13'h0001
		&& tx_pkt_pending;

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			tx_purge_active <= 1'b0;
			purge_cnt       <= 13'h0000;
		end else if (tx_link_err) begin
			tx_purge_active <= 1'b1;
			purge_cnt       <= 13'h0000;
		end else if (tx_purge_active) begin
			purge_cnt <= purge_cnt + 13'h0001;
			if (purge_cnt == PURGE_LIM - 13'h0001 || !tx_pkt_pending) begin
				tx_purge_active <= 1'b0;
			end
		end
	end

	// ****************************************
	// Time code and input DMA
	// ****************************************
	logic [TC_W-1:0] tc_value;
	logic            tc_tick;
	lcsfd_dma_if     dma_bus ();

	lcsfd_timecode u_timecode (
		.core_clk  (core_clk),
		.reset     (reset),
		.tc_strobe (tc_strobe),
		.tc_code   (tc_code),
		.tc_value  (tc_value),
		.tc_tick   (tc_tick)
	);

	assign dma_bus.start = ptr_wr && host_wdata != 32'h0000_0000;
	assign dma_bus.abort = ptr_wr && host_wdata == 32'h0000_0000;
	assign dma_bus.ptr   = host_wdata;

	lcsfd_dma_chain u_dma_chain (
		.core_clk    (core_clk),
		.reset       (reset),
		.dma         (dma_bus.eng),
		.mem_rd_req  (mem_rd_req),
		.mem_rd_addr (mem_rd_addr),
		.mem_rd_ack  (mem_rd_ack),
		.mem_rd_data (mem_rd_data),
		.mem_abort   (mem_abort),
		.seg_start   (seg_start),
		.seg_addr    (seg_addr),
		.seg_words   (seg_words),
		.seg_done    (seg_done)
	);

	// ****************************************
	// Status word
	// ****************************************
	logic [31:0] stat_lat;
	logic [31:0] stat_set;
	logic [31:0] stat_clr;
	logic [31:0] status_word;
	logic        tx_ae;
	logic        rx_af;
	logic        ovfl;
	logic        int_active;

	assign tx_ae = tx_fifo_count <= tx_low_threshold;
	assign rx_af = rx_fifo_count >= rx_high_threshold;
	assign ovfl  = (rx_fifo_wr_try && rx_fifo_full) || (rx_plen_wr_try && rx_plen_full);

	always_comb begin
		stat_set              = 32'h0000_0000;
		stat_set[B_PARITY]    = parity_err;
		stat_set[B_DISC]      = disc_hit;
		stat_set[B_ESC]       = escape_err;
		stat_set[B_CREDIT]    = credit_err;
		stat_set[B_OVFL]      = ovfl;
		stat_set[B_RX_ERR]    = parity_err || disc_hit || escape_err || credit_err || ovfl;
		stat_set[B_PKT]       = pkt_received;
		stat_set[B_TICK]      = tc_tick;
		stat_set[B_WR_DONE]   = dma_bus.done;
		stat_set[B_RD_DONE]   = rd_dma_done;
		stat_set[B_WR_ERR]    = dma_bus.err;
		stat_set[B_RD_ERR]    = rd_dma_err;
		stat_set[B_PURGE]     = purge_fail;
		stat_set[B_TX_AE_LAT] = tx_ae;
		stat_set[B_RX_AF_LAT] = rx_af;
	end

	assign stat_clr = stat_wr ? (host_wdata & STAT_W1C_MASK) : 32'h0000_0000;

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			stat_lat <= STAT_RESET;
		end else begin
			stat_lat <= (stat_lat & ~stat_clr) | stat_set;
		end
	end

	assign int_active = (tx_ae_int_en && tx_ae) || (rx_af_int_en && rx_af)
		|| (rx_err_int_en && stat_lat[B_RX_ERR]) || (pkt_int_en && stat_lat[B_PKT])
		|| (tick_int_en && stat_lat[B_TICK]) || force_int;

	always_comb begin
		status_word                          = stat_lat & STAT_W1C_MASK;
		status_word[B_TX_EMPTY]              = tx_fifo_count == 11'h000;
		status_word[B_TX_AE]                 = tx_ae;
		status_word[B_TX_FULL]               = tx_fifo_full;
		status_word[B_TX_VALID]              = tx_word_valid || tx_pop_pend;
		status_word[B_RX_EMPTY]              = rx_fifo_count == 11'h000;
		status_word[B_RX_AF]                 = rx_af;
		status_word[B_RX_FULL]               = rx_fifo_full;
		status_word[B_RX_VALID]              = rx_fifo_count != 11'h000
			|| pf_count != 3'h0 || rx_pop_pend;
		status_word[B_LINK_RUN]              = link_run;
		status_word[B_PLEN_VALID]            = rx_plen_avail;
		status_word[B_INT_ACT]               = int_active;
		status_word[B_TC_LO+TC_W-1:B_TC_LO]  = tc_value;
	end

	// ****************************************
	// Read data and interrupt
	// ****************************************
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			host_rdata <= 32'h0000_0000;
			host_irq   <= 1'b0;
		end else begin
			host_irq <= (master_int_en && int_active)
				|| (wr_dma_int_en && stat_lat[B_WR_DONE])
				|| (rd_dma_int_en && stat_lat[B_RD_DONE]);
			if (host_rd && host_addr == OFF_STATUS) begin
				host_rdata <= status_word;
			end else if (data_rd) begin
				host_rdata <= pf_count != 3'h0 ? pf_data[0] : 32'h0000_0000;
			end else begin
				host_rdata <= 32'h0000_0000;
			end
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	AST_RX_EMPTY: assert property (@(posedge core_clk) disable iff (reset)
		rx_fifo_count == 11'h000 && pf_count == 3'h0 && !rx_pop_pend |-> !status_word[B_RX_VALID])
		else $error("receive valid shown with nothing held");
	AST_TX_HOLD: assert property (@(posedge core_clk) disable iff (reset)
		tx_fifo_pop |=> status_word[B_TX_VALID] ##1 tx_word_valid)
		else $error("transmit word not held after pop");
	AST_PF_LIMIT: assert property (@(posedge core_clk) disable iff (reset)
		pf_count <= 3'(PF_DEPTH) && !(pf_count == 3'(PF_DEPTH) && rx_fifo_pop))
		else $error("more than four prefetch words");
	AST_PARITY: assert property (@(posedge core_clk) disable iff (reset)
		parity_err |=> stat_lat[B_PARITY] && stat_lat[B_RX_ERR])
		else $error("parity error not latched");
	AST_DISC: assert property (@(posedge core_clk) disable iff (reset)
		disc_hit |-> $past(link_enable) && idle_cnt == DISC_LIMIT - 8'h01)
		else $error("disconnect flagged at the wrong idle time");
	AST_W1C_HOLD: assert property (@(posedge core_clk) disable iff (reset)
		stat_wr && !host_wdata[B_CREDIT] && stat_lat[B_CREDIT] |=> stat_lat[B_CREDIT])
		else $error("latched bit lost on a zero write");
	AST_SET_WINS: assert property (@(posedge core_clk) disable iff (reset)
		pkt_received && stat_wr && host_wdata[B_PKT] |=> stat_lat[B_PKT])
		else $error("packet event lost against a clear");
	AST_IRQ_GATE: assert property (@(posedge core_clk) disable iff (reset)
		!master_int_en && !wr_dma_int_en && !rd_dma_int_en |=> !host_irq)
		else $error("interrupt passed with every gate closed");
	AST_PURGE: assert property (@(posedge core_clk) disable iff (reset)
		tx_link_err |=> tx_purge_active)
		else $error("purge did not start after link error");
endmodule // lcsfd_top
`default_nettype wire

/* File: sim/lcsfd_mem_model.sv */
// Descriptor memory and segment mover at the far side of the input DMA
`timescale 1ns/10ps
`default_nettype none
module lcsfd_mem_model (
	// Clock
	input  wire logic        core_clk,
	// Descriptor reads
	input  wire logic        mem_rd_req,
	input  wire logic [31:0] mem_rd_addr,
	output logic             mem_rd_ack = 1'b0,
	output logic      [31:0] mem_rd_data = 32'h0,
	// Segments
	input  wire logic        seg_start,
	output logic             seg_done = 1'b0
);
	logic [2:0] seg_dly = 3'h0;
	always @(posedge core_clk) begin
		mem_rd_ack <= mem_rd_req & ~mem_rd_ack;
		if (mem_rd_req & ~mem_rd_ack) begin
			case (mem_rd_addr[3:2])
				2'h0: mem_rd_data <= 32'h0000_2000;
				2'h1: mem_rd_data <= 32'h0000_0010;
				default: mem_rd_data <= 32'h0000_0001;
			endcase
		end else begin
			mem_rd_data <= ~mem_rd_data;
		end
		seg_dly <= {seg_dly[1:0], seg_start};
		seg_done <= seg_dly[2];
	end
endmodule // lcsfd_mem_model
`default_nettype wire

/* File: sim/tb.sv */
// Self-checking bench for the channel status word, data port and input DMA pointer
`timescale 1ns/10ps
`default_nettype none
module tb;
	import lcsfd_pkg::*;
	logic core_clk, reset = 1'b1;
	logic host_wr='0, host_rd='0, tx_enable='0, bypass_enable='0, link_enable='0;
	logic master_int_en='0, tx_ae_int_en='0, rx_af_int_en='0, rx_err_int_en='0, pkt_int_en='0;
	logic tick_int_en='0, force_int='0, wr_dma_int_en='0, rd_dma_int_en='0, tx_fifo_full='0;
	logic tx_word_take='0, rx_fifo_full='0, rx_dma_take='0, rx_fifo_wr_try='0, rx_plen_wr_try='0;
	logic rx_plen_full='0, rx_plen_avail='0, parity_err='0, escape_err='0, credit_err='0;
	logic pkt_received='0, tc_strobe='0, lnk_data_in='0, lnk_strobe_in='0, link_run='0;
	logic tx_link_err='0, tx_pkt_pending='0, mem_abort='0, rd_dma_done='0, rd_dma_err='0;
	logic [CNT_W-1:0] tx_low_threshold=11'h002, rx_high_threshold=11'h004;
	logic [CNT_W-1:0] tx_fifo_count='0, rx_fifo_count='0;
	logic [7:0] host_addr='0;
	logic [TC_W-1:0] tc_code='0;
	logic [31:0] host_wdata='0, tx_fifo_rdata='0, rx_fifo_rdata='0, rdv;
	logic host_irq, tx_fifo_push, tx_fifo_pop, tx_word_valid, rx_fifo_pop, rx_dma_valid;
	logic tx_purge_active, mem_rd_req, mem_rd_ack, seg_start, seg_done;
	logic [31:0] host_rdata, tx_fifo_wdata, tx_word, rx_dma_word, mem_rd_addr, mem_rd_data, seg_addr;
	logic [SEG_W-1:0] seg_words;
	int num_errors = 0, check_count = 0;

	lcsfd_top #(.PURGE_CYC(20)) i_dut (.*);
	lcsfd_mem_model i_mem (.*);

	initial begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end

	// ****************************************
	// Host access and checking
	// ****************************************
	task step;
		@(posedge core_clk);
		#1;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		host_addr = a;
		host_wdata = d;
		host_wr = 1'b1;
		step;
		host_wr = 1'b0;
	endtask
	task rd(input logic [7:0] a);
		host_addr = a;
		host_rd = 1'b1;
		step;
		rdv = host_rdata;
		host_rd = 1'b0;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] m, input logic [31:0] e);
		check_count++;
		if ((got & m) !== e) begin
			num_errors++;
			$display("CHECK FAILED %0t: got %h want %h", $time, got & m, e);
		end
	endtask
	task finish_test;
		$display("errors %0d checks %0d", num_errors, check_count);
		if (num_errors == 0 && check_count > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask

	initial begin
		#40000;
		num_errors++;
		finish_test;
	end

	initial begin
		repeat (12) @(posedge core_clk);
		#1 reset = 1'b0;
		step;
		rd(OFF_STATUS);
		chk(rdv, 32'hffff_ffff, 32'h4000_0013);
		parity_err = 1'b1;
		step;
		parity_err = 1'b0;
		wr(OFF_STATUS, 32'h0);
		rd(OFF_STATUS);
		chk(rdv, 32'h2300, 32'h2100);
		wr(OFF_STATUS, 32'h100);
		rd(OFF_STATUS);
		chk(rdv, 32'h2300, 32'h2000);
		wr(OFF_DATA, 32'hcafe_0001);
		chk({31'h0, tx_fifo_push}, 32'h1, 32'h1);
		chk(tx_fifo_wdata, 32'hffff_ffff, 32'hcafe_0001);
		for (int i = 0; i < 2; i++) begin
			tc_code = 6'h05 + 6'(i);
			tc_strobe = 1'b1;
			step;
			tc_strobe = 1'b0;
			repeat (2) step;
			rd(OFF_STATUS);
			chk(rdv, 32'h3f00_8000, {2'h0, tc_code, 8'h0, i[0], 15'h0});
		end
		link_enable = 1'b1;
		link_run = 1'b1;
		tx_pkt_pending = 1'b1;
		tx_link_err = 1'b1;
		step;
		tx_link_err = 1'b0;
		repeat (230) step;
		rd(OFF_STATUS);
		chk(rdv, 32'h0030_0200, 32'h0030_0200);
		wr_dma_int_en = 1'b1;
		wr(OFF_DMA_PTR, 32'h0000_0100);
		rdv = '0;
		repeat (60) if (rdv[B_WR_DONE] !== 1'b1) rd(OFF_STATUS);
		chk(rdv, 32'h0005_0000, 32'h0001_0000);
		chk({12'h0, seg_words}, 32'hffff_ffff, 32'h4);
		chk({31'h0, host_irq}, 32'h1, 32'h1);
		wr(OFF_DMA_PTR, 32'h0000_0102);
		repeat (2) step;
		rd(OFF_STATUS);
		chk(rdv, 32'h0004_0000, 32'h0004_0000);
		escape_err = 1'b1;
		credit_err = 1'b1;
		rx_fifo_full = 1'b1;
		rx_fifo_wr_try = 1'b1;
		rx_plen_avail = 1'b1;
		force_int = 1'b1;
		pkt_received = 1'b1;
		wr(OFF_STATUS, 32'h0000_4000);
		escape_err = 1'b0;
		credit_err = 1'b0;
		rx_fifo_full = 1'b0;
		rx_fifo_wr_try = 1'b0;
		pkt_received = 1'b0;
		rd(OFF_STATUS);
		chk(rdv, 32'h00c0_5c00, 32'h00c0_5c00);
		tx_enable = 1'b1;
		tx_fifo_count = 11'h001;
		tx_fifo_rdata = 32'h1234_5678;
		rx_fifo_count = 11'h001;
		rx_fifo_rdata = 32'hbeef_0001;
		step;
		tx_fifo_count = 11'h000;
		rx_fifo_count = 11'h000;
		repeat (2) step;
		rd(OFF_STATUS);
		chk(rdv, 32'h0000_0099, 32'h0000_0099);
		chk(tx_word, 32'hffff_ffff, 32'h1234_5678);
		chk(rx_dma_word, 32'hffff_ffff, 32'hbeef_0001);
		rd(OFF_DATA);
		chk(rdv, 32'hffff_ffff, 32'hbeef_0001);
		finish_test;
	end
endmodule // tb
`default_nettype wire
